// ### dv/mcr_host_model.sv
// Host side of the serial port: frames commands and data
`timescale 1ns/100ps
`default_nettype none
module mcr_host_model (
	input  wire logic i_clk,
	input  wire logic i_dout,
	output var logic  o_sclk,
	output var logic  o_cs_n,
	output var logic  o_din
);
	initial begin
		o_sclk = 1'b0;
		o_cs_n = 1'b1;
		o_din  = 1'b0;
	end
	// ****************************************
	// Frame task
	// ****************************************
	// Five clocks per phase keeps margin over the device's three-flop sync
	task automatic xfer(input logic [7:0] cmd, input int nbits, input logic [15:0] wdata,
		output logic [15:0] rdata);
		logic [23:0] sh;
		int          n;
		sh = {cmd, wdata << (16 - nbits)};
		rdata = 16'h0000;
		@(posedge i_clk) o_cs_n <= 1'b0;
		repeat (3) @(posedge i_clk);
		for (n = 0; n < 8 + nbits; n++) begin
			@(posedge i_clk);
			o_sclk <= 1'b1;
			o_din <= sh[23 - n];
			repeat (5) @(posedge i_clk);
			o_sclk <= 1'b0;
			rdata = {rdata[14:0], i_dout};
			repeat (4) @(posedge i_clk);
		end
		@(posedge i_clk);
		o_cs_n <= 1'b1;
		o_din <= ~o_din;
		repeat (12) @(posedge i_clk);
	endtask
endmodule // mcr_host_model
`default_nettype wire

// ### dv/mcr_regs_props.sv
// Concurrent checks on the calibration register bank ports
`timescale 1ns/100ps
`default_nettype none
module mcr_regs_props (
	input wire logic        i_clk,
	input wire logic        i_reset,
	input wire logic        i_cs_n,
	input wire logic [7:0]  i_voltage_level,
	input wire logic        i_voltage_valid,
	input wire logic [7:0]  i_current_level,
	input wire logic        i_current_valid,
	input wire logic        i_peak_flags_clear,
	input wire logic        o_dout_oe_q,
	input wire logic [15:0] o_line_cycle_count_q,
	input wire logic [7:0]  o_sag_threshold_level_q,
	input wire logic [7:0]  o_voltage_peak_threshold_q,
	input wire logic [7:0]  o_current_peak_threshold_q,
	input wire logic [11:0] o_pulse_scale_denominator_q,
	input wire logic        o_voltage_peak_flag_q,
	input wire logic        o_current_peak_flag_q
);
	// ****************************************
	// Helper logic
	// ****************************************
	logic [3:0] idle_q;
	logic       v_hit;
	logic       i_hit;
	assign v_hit = i_voltage_valid && (i_voltage_level > o_voltage_peak_threshold_q);
	assign i_hit = i_current_valid && (i_current_level > o_current_peak_threshold_q);
	// Saturates so that a long idle time never wraps back into the write window
	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset || !i_cs_n) begin
			idle_q <= 4'h0;
		end else if (idle_q != 4'hF) begin
			idle_q <= idle_q + 4'h1;
		end
	end
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_reset);
	a_voltage_peak_threshold_set: assert property (v_hit |-> ##2 o_voltage_peak_flag_q)
		else $error("voltage peak flag not set");
	a_current_peak_threshold_set: assert property (i_hit |-> ##2 o_current_peak_flag_q)
		else $error("current peak flag not set");
	a_voltage_peak_threshold_cause: assert property ($rose(o_voltage_peak_flag_q) |-> $past(v_hit, 2))
		else $error("voltage peak flag set without cause");
	a_current_peak_threshold_cause: assert property ($rose(o_current_peak_flag_q) |-> $past(i_hit, 2))
		else $error("current peak flag set without cause");
	a_voltage_peak_threshold_clear: assert property (i_peak_flags_clear && !v_hit && !$past(v_hit) |=> !o_voltage_peak_flag_q)
		else $error("voltage peak flag not cleared");
	a_current_peak_threshold_clear: assert property (i_peak_flags_clear && !i_hit && !$past(i_hit) |=> !o_current_peak_flag_q)
		else $error("current peak flag not cleared");
	a_flag_sticky: assert property (o_voltage_peak_flag_q && !i_peak_flags_clear |=> o_voltage_peak_flag_q)
		else $error("voltage peak flag dropped");
	a_iflag_sticky: assert property (o_current_peak_flag_q && !i_peak_flags_clear |=> o_current_peak_flag_q)
		else $error("current peak flag dropped");
	a_regs_quiet: assert property (idle_q == 4'hF |=> $stable({o_line_cycle_count_q, o_sag_threshold_level_q,
		o_voltage_peak_threshold_q, o_pulse_scale_denominator_q}))
		else $error("register changed outside a frame");
	a_oe_idle: assert property (idle_q >= 4'h8 |-> !o_dout_oe_q)
		else $error("data out driven while deselected");
	c_voltage_peak_threshold: cover property ($rose(o_voltage_peak_flag_q));
	c_read: cover property ($rose(o_dout_oe_q));
	c_write: cover property ($changed(o_line_cycle_count_q));
endmodule // mcr_regs_props
bind mcr_regs mcr_regs_props u_props (.i_clk(i_clk), .i_reset(i_reset), .i_cs_n(i_cs_n),
	.i_voltage_level(i_voltage_level), .i_voltage_valid(i_voltage_valid), .i_current_level(i_current_level),
	.i_current_valid(i_current_valid), .i_peak_flags_clear(i_peak_flags_clear), .o_dout_oe_q(o_dout_oe_q),
	.o_line_cycle_count_q(o_line_cycle_count_q), .o_sag_threshold_level_q(o_sag_threshold_level_q),
	.o_voltage_peak_threshold_q(o_voltage_peak_threshold_q),
	.o_current_peak_threshold_q(o_current_peak_threshold_q),
	.o_pulse_scale_denominator_q(o_pulse_scale_denominator_q),
	.o_voltage_peak_flag_q(o_voltage_peak_flag_q), .o_current_peak_flag_q(o_current_peak_flag_q));
`default_nettype wire

// ### dv/tb_mcr_regs.sv
// Self-checking bench for the calibration register bank
`timescale 1ns/100ps
`default_nettype none
module tb_mcr_regs;
	logic         i_clk, i_reset, vv, iv, clr, oe_seen;
	logic [7:0]   vl, il;
	logic [15:0]  rd;
	logic [5:0]   a;
	int           error_cnt, n_tests;
	wire          sclk, cs_n, din, dout, oe, vf, cf;
	wire  [15:0]  r13;
	wire  [7:0]   r14, r15, r16, r17, r18, r27;
	wire  [11:0]  r19, r1a, r1b, r1c, r1d, r1e, r22, r23, r24, r25, r26;
	wire  [4:0]   r1f, r20, r21;
	wire  [335:0] all_q;
	assign all_q = {8'h00, r27, 4'h0, r26, 4'h0, r25, 4'h0, r24, 4'h0, r23, 4'h0, r22, 11'h000, r21, 11'h000,
		r20, 11'h000, r1f, 4'h0, r1e, 4'h0, r1d, 4'h0, r1c, 4'h0, r1b, 4'h0, r1a, 4'h0, r19, 8'h00, r18,
		8'h00, r17, 8'h00, r16, 8'h00, r15, 8'h00, r14, r13};
	mcr_regs dut (.i_clk(i_clk), .i_reset(i_reset), .i_sclk(sclk), .i_cs_n(cs_n), .i_din(din),
		.i_voltage_level(vl), .i_voltage_valid(vv), .i_current_level(il), .i_current_valid(iv),
		.i_peak_flags_clear(clr), .o_dout_q(dout), .o_dout_oe_q(oe), .o_line_cycle_count_q(r13),
		.o_sag_half_cycle_count_q(r14), .o_sag_threshold_level_q(r15), .o_voltage_peak_threshold_q(r16),
		.o_current_peak_threshold_q(r17), .o_amplifier_gain_config_q(r18), .o_phase_a_watt_gain_q(r19),
		.o_phase_b_watt_gain_q(r1a), .o_phase_c_watt_gain_q(r1b), .o_phase_a_apparent_gain_q(r1c),
		.o_phase_b_apparent_gain_q(r1d), .o_phase_c_apparent_gain_q(r1e), .o_phase_a_phase_trim_q(r1f),
		.o_phase_b_phase_trim_q(r20), .o_phase_c_phase_trim_q(r21), .o_phase_a_power_offset_q(r22),
		.o_phase_b_power_offset_q(r23), .o_phase_c_power_offset_q(r24), .o_pulse_scale_numerator_q(r25),
		.o_pulse_scale_denominator_q(r26), .o_active_energy_divider_q(r27), .o_voltage_peak_flag_q(vf),
		.o_current_peak_flag_q(cf));
	mcr_host_model host (.i_clk(i_clk), .i_dout(dout), .o_sclk(sclk), .o_cs_n(cs_n), .o_din(din));
	initial begin
		i_clk = 1'b0;
		forever #5 i_clk = ~i_clk;
	end
	// Remembers whether the device drove its data pin since the last clear
	always @(posedge i_clk) begin
		if (oe === 1'b1) begin
			oe_seen <= 1'b1;
		end
	end
	// ****************************************
	// Helpers
	// ****************************************
	function automatic int wid(input logic [5:0] x);
		case (x)
			6'h13: return 16;
			6'h12, 6'h14, 6'h15, 6'h16, 6'h17, 6'h18, 6'h27, 6'h28: return 8;
			6'h1F, 6'h20, 6'h21: return 5;
			default: return 12;
		endcase
	endfunction
	function automatic logic [15:0] rst(input logic [5:0] x);
		case (x)
			6'h13: return 16'hFFFF;
			6'h14, 6'h16, 6'h17: return 16'h00FF;
			6'h26: return 16'h003F;
			default: return 16'h0000;
		endcase
	endfunction
	// Raw pattern sets bits above each width below 16 bits, except at 6'h16, so truncation is exercised
	function automatic logic [15:0] raw(input logic [5:0] x);
		return {x, 2'b10, x, 2'b01} ^ 16'h5AA5;
	endfunction
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			error_cnt++;
			$display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic rd_reg(input logic [5:0] x, input logic [15:0] exp);
		host.xfer({2'b00, x}, (wid(x) > 8) ? 16 : 8, 16'h0000, rd);
		check(rd & ((wid(x) > 8) ? 16'hFFFF : 16'h00FF), exp);
	endtask
	task automatic ports_are(input logic at_reset);
		for (int k = 6'h13; k <= 6'h27; k++) begin
			check(all_q[(k - 6'h13) * 16 +: 16], at_reset ? rst(k) : raw(k) & (16'hFFFF >> (16 - wid(k))));
		end
	endtask
	task automatic peak(input logic [7:0] v, input logic [7:0] i, input logic [1:0] exp);
		@(posedge i_clk);
		vl <= v;
		il <= i;
		{vv, iv} <= 2'b11;
		@(posedge i_clk);
		{vv, iv} <= 2'b00;
		repeat (3) @(posedge i_clk);
		check({14'h0000, vf, cf}, {14'h0000, exp});
		clr <= 1'b1;
		@(posedge i_clk);
		clr <= 1'b0;
		repeat (2) @(posedge i_clk);
		check({14'h0000, vf, cf}, 16'h0000);
	endtask
	task automatic summarize;
		$display("Comparisons %0d, mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		{i_reset, vv, iv, clr} = 4'b1000;
		vl = 8'h00;
		il = 8'h00;
		error_cnt = 0;
		oe_seen = 1'b0;
		n_tests = 0;
		repeat (6) @(posedge i_clk);
		i_reset <= 1'b0;
		repeat (4) @(posedge i_clk);
		ports_are(1'b1);
		for (a = 6'h13; a <= 6'h27; a++) rd_reg(a, rst(a));
		check({15'h0000, oe_seen}, 16'h0001);
		oe_seen <= 1'b0;
		for (a = 6'h13; a <= 6'h27; a++) host.xfer({2'b10, a}, (wid(a) > 8) ? 16 : 8, raw(a), rd);
		// Write frames must never turn the data pin around
		check({15'h0000, oe_seen}, 16'h0000);
		ports_are(1'b0);
		for (a = 6'h13; a <= 6'h27; a++) rd_reg(a, raw(a) & (16'hFFFF >> (16 - wid(a))));
		// Aborted frame and unmapped write must leave every register alone
		host.xfer(8'h95, 4, 16'h000F, rd);
		host.xfer(8'hA8, 8, 16'h00FF, rd);
		ports_are(1'b0);
		rd_reg(6'h28, 16'h0000);
		rd_reg(6'h12, 16'h0000);
		// Command bit 6 is a don't-care, so this write must still land
		host.xfer(8'hD6, 8, 16'h0040, rd);
		host.xfer(8'h97, 8, 16'h0040, rd);
		peak(8'h41, 8'h40, 2'b10);
		peak(8'h40, 8'h41, 2'b01);
		peak(8'hFF, 8'h80, 2'b11);
		i_reset <= 1'b1;
		repeat (2) @(posedge i_clk);
		i_reset <= 1'b0;
		repeat (4) @(posedge i_clk);
		ports_are(1'b1);
		summarize();
	end
	initial begin
		repeat (100000) @(posedge i_clk);
		error_cnt++;
		summarize();
	end
endmodule // tb_mcr_regs
`default_nettype wire

// ### hw/mcr_defs.vh
// Constants for the metering calibration register bank
//
// Function
// - The 16-bit line cycle count, reset to all ones, sets how many half line cycles line energy accumulates over.
// - The 8-bit sag half cycle count, reset to all ones, is the number of low half cycles that make a sag, for all phases.
// - One 8-bit sag threshold level, reset to zero, is the sag compare level shared by all three phases.
// - The voltage peak flag is set when the selected voltage exceeds the 8-bit voltage peak threshold, reset all ones.
// - The current peak flag is set when the selected current exceeds the 8-bit current peak threshold, reset all ones.
// - One 8-bit amplifier gain register selects channel gains, the no-load threshold and the absolute sum option.
// - Each phase has a 12-bit watt gain register, reset to zero, that calibrates its active power.
// - Each phase has a 12-bit apparent gain register, reset to zero, for apparent power calibration.
// - Each phase has a 5-bit phase trim register, reset to zero.
// - Each phase has a 12-bit power offset register, reset to zero.
// - A 12-bit pulse scale numerator, reset to zero, scales the calibrated pulse output.
// - A 12-bit pulse scale denominator, reset to 3Fh, scales the calibrated pulse output.
// - An 8-bit active energy divider, reset to zero, divides the active energy contents.
`ifndef MCR_DEFS_VH
`define MCR_DEFS_VH

// ****************************************
// Serial command byte
// ****************************************
`define MCR_CMD_WRITE_BIT      7
`define MCR_CMD_BITS           5'h08

// ****************************************
// Register addresses
// ****************************************
`define MCR_ADDR_LINE_CYC      6'h13
`define MCR_ADDR_SAG_CYC       6'h14
`define MCR_ADDR_SAG_LVL       6'h15
`define MCR_ADDR_V_PEAK        6'h16
`define MCR_ADDR_I_PEAK        6'h17
`define MCR_ADDR_GAIN_CFG      6'h18
`define MCR_ADDR_A_WATT_GAIN   6'h19
`define MCR_ADDR_B_WATT_GAIN   6'h1A
`define MCR_ADDR_C_WATT_GAIN   6'h1B
`define MCR_ADDR_A_APP_GAIN    6'h1C
`define MCR_ADDR_B_APP_GAIN    6'h1D
`define MCR_ADDR_C_APP_GAIN    6'h1E
`define MCR_ADDR_A_PH_TRIM     6'h1F
`define MCR_ADDR_B_PH_TRIM     6'h20
`define MCR_ADDR_C_PH_TRIM     6'h21
`define MCR_ADDR_A_PWR_OFS     6'h22
`define MCR_ADDR_B_PWR_OFS     6'h23
`define MCR_ADDR_C_PWR_OFS     6'h24
`define MCR_ADDR_PULSE_NUM     6'h25
`define MCR_ADDR_PULSE_DEN     6'h26
`define MCR_ADDR_ENERGY_DIV    6'h27

// ****************************************
// Reset values
// ****************************************
`define MCR_RST_LINE_CYC       16'hFFFF
`define MCR_RST_SAG_CYC        8'hFF
`define MCR_RST_SAG_LVL        8'h00
`define MCR_RST_V_PEAK         8'hFF
`define MCR_RST_I_PEAK         8'hFF
`define MCR_RST_GAIN_CFG       8'h00
`define MCR_RST_CAL12          12'h000
`define MCR_RST_PH_TRIM        5'h00
`define MCR_RST_PULSE_NUM      12'h000
`define MCR_RST_PULSE_DEN      12'h03F
`define MCR_RST_ENERGY_DIV     8'h00

`endif

// ### hw/mcr_regs.v
// Metering calibration register bank with serial access and peak compare
`timescale 1ns/100ps
`default_nettype none
`include "mcr_defs.vh"

module mcr_regs (
	input  wire        i_clk,
	input  wire        i_reset,
	input  wire        i_sclk,
	input  wire        i_cs_n,
	input  wire        i_din,
	input  wire [7:0]  i_voltage_level,
	input  wire        i_voltage_valid,
	input  wire [7:0]  i_current_level,
	input  wire        i_current_valid,
	input  wire        i_peak_flags_clear,
	output reg         o_dout_q,
	output reg         o_dout_oe_q,
	output reg  [15:0] o_line_cycle_count_q,
	output reg  [7:0]  o_sag_half_cycle_count_q,
	output reg  [7:0]  o_sag_threshold_level_q,
	output reg  [7:0]  o_voltage_peak_threshold_q,
	output reg  [7:0]  o_current_peak_threshold_q,
	output reg  [7:0]  o_amplifier_gain_config_q,
	output reg  [11:0] o_phase_a_watt_gain_q,
	output reg  [11:0] o_phase_b_watt_gain_q,
	output reg  [11:0] o_phase_c_watt_gain_q,
	output reg  [11:0] o_phase_a_apparent_gain_q,
	output reg  [11:0] o_phase_b_apparent_gain_q,
	output reg  [11:0] o_phase_c_apparent_gain_q,
	output reg  [4:0]  o_phase_a_phase_trim_q,
	output reg  [4:0]  o_phase_b_phase_trim_q,
	output reg  [4:0]  o_phase_c_phase_trim_q,
	output reg  [11:0] o_phase_a_power_offset_q,
	output reg  [11:0] o_phase_b_power_offset_q,
	output reg  [11:0] o_phase_c_power_offset_q,
	output reg  [11:0] o_pulse_scale_numerator_q,
	output reg  [11:0] o_pulse_scale_denominator_q,
	output reg  [7:0]  o_active_energy_divider_q,
	output reg         o_voltage_peak_flag_q,
	output reg         o_current_peak_flag_q
);

	// ****************************************
	// Serial engine
	// ****************************************
	wire [5:0]  reg_addr;
	wire        wr_pulse;
	wire [15:0] wdata;
	wire        dout;
	wire        dout_oe;
	reg  [15:0] rdata;

	mcr_serial_port u_port (
		.i_clk        (i_clk),
		.i_reset      (i_reset),
		.i_sclk       (i_sclk),
		.i_cs_n       (i_cs_n),
		.i_din        (i_din),
		.i_rdata      (rdata),
		.o_addr_q     (reg_addr),
		.o_wr_pulse_q (wr_pulse),
		.o_wdata_q    (wdata),
		.o_dout_q     (dout),
		.o_dout_oe_q  (dout_oe)
	);

	// Retimed so that every top-level output leaves from a local flop
	always @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			o_dout_q    <= 1'b0;
			o_dout_oe_q <= 1'b0;
		end else begin
			o_dout_q    <= dout;
			o_dout_oe_q <= dout_oe;
		end
	end

	// ****************************************
	// Level sampling
	// ****************************************
	// Levels come from the metering datapath on this clock, so no synchroniser
	reg        v_over_q;
	reg        i_over_q;

	always @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			v_over_q <= 1'b0;
			i_over_q <= 1'b0;
		end else begin
			v_over_q <= i_voltage_valid && (i_voltage_level > o_voltage_peak_threshold_q);
			i_over_q <= i_current_valid && (i_current_level > o_current_peak_threshold_q);
		end
	end

	// ****************************************
	// Peak flags
	// ****************************************
	// An excursion in the cycle before the clearing cycle keeps the flag set
	always @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			o_voltage_peak_flag_q <= 1'b0;
			o_current_peak_flag_q <= 1'b0;
		end else begin
			if (v_over_q) begin
				o_voltage_peak_flag_q <= 1'b1;
			end else if (i_peak_flags_clear) begin
				o_voltage_peak_flag_q <= 1'b0;
			end
			if (i_over_q) begin
				o_current_peak_flag_q <= 1'b1;
			end else if (i_peak_flags_clear) begin
				o_current_peak_flag_q <= 1'b0;
			end
		end
	end

	// ****************************************
	// Address decode
	// ****************************************
	// Neighbouring addresses belong to other register groups of the device
	function in_bank;
		input [5:0] addr;
		begin
			in_bank = (addr >= `MCR_ADDR_LINE_CYC) && (addr <= `MCR_ADDR_ENERGY_DIV);
		end
	endfunction

	// ****************************************
	// Register writes
	// ****************************************
	// Upper bits of the write word beyond a register's width are discarded
	always @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			o_line_cycle_count_q        <= `MCR_RST_LINE_CYC;
			o_sag_half_cycle_count_q    <= `MCR_RST_SAG_CYC;
			o_sag_threshold_level_q     <= `MCR_RST_SAG_LVL;
			o_voltage_peak_threshold_q  <= `MCR_RST_V_PEAK;
			o_current_peak_threshold_q  <= `MCR_RST_I_PEAK;
			o_amplifier_gain_config_q   <= `MCR_RST_GAIN_CFG;
			o_phase_a_watt_gain_q       <= `MCR_RST_CAL12;
			o_phase_b_watt_gain_q       <= `MCR_RST_CAL12;
			o_phase_c_watt_gain_q       <= `MCR_RST_CAL12;
			o_phase_a_apparent_gain_q   <= `MCR_RST_CAL12;
			o_phase_b_apparent_gain_q   <= `MCR_RST_CAL12;
			o_phase_c_apparent_gain_q   <= `MCR_RST_CAL12;
			o_phase_a_phase_trim_q      <= `MCR_RST_PH_TRIM;
			o_phase_b_phase_trim_q      <= `MCR_RST_PH_TRIM;
			o_phase_c_phase_trim_q      <= `MCR_RST_PH_TRIM;
			o_phase_a_power_offset_q    <= `MCR_RST_CAL12;
			o_phase_b_power_offset_q    <= `MCR_RST_CAL12;
			o_phase_c_power_offset_q    <= `MCR_RST_CAL12;
			o_pulse_scale_numerator_q   <= `MCR_RST_PULSE_NUM;
			o_pulse_scale_denominator_q <= `MCR_RST_PULSE_DEN;
			o_active_energy_divider_q   <= `MCR_RST_ENERGY_DIV;
		end else if (wr_pulse && in_bank(reg_addr)) begin
			case (reg_addr)
			`MCR_ADDR_LINE_CYC: begin
				o_line_cycle_count_q <= wdata;
			end
			`MCR_ADDR_SAG_CYC: begin
				o_sag_half_cycle_count_q <= wdata[7:0];
			end
			`MCR_ADDR_SAG_LVL: begin
				o_sag_threshold_level_q <= wdata[7:0];
			end
			`MCR_ADDR_V_PEAK: begin
				o_voltage_peak_threshold_q <= wdata[7:0];
			end
			`MCR_ADDR_I_PEAK: begin
				o_current_peak_threshold_q <= wdata[7:0];
			end
			`MCR_ADDR_GAIN_CFG: begin
				o_amplifier_gain_config_q <= wdata[7:0];
			end
			`MCR_ADDR_A_WATT_GAIN: begin
				o_phase_a_watt_gain_q <= wdata[11:0];
			end
			`MCR_ADDR_B_WATT_GAIN: begin
				o_phase_b_watt_gain_q <= wdata[11:0];
			end
			`MCR_ADDR_C_WATT_GAIN: begin
				o_phase_c_watt_gain_q <= wdata[11:0];
			end
			`MCR_ADDR_A_APP_GAIN: begin
				o_phase_a_apparent_gain_q <= wdata[11:0];
			end
			`MCR_ADDR_B_APP_GAIN: begin
				o_phase_b_apparent_gain_q <= wdata[11:0];
			end
			`MCR_ADDR_C_APP_GAIN: begin
				o_phase_c_apparent_gain_q <= wdata[11:0];
			end
			`MCR_ADDR_A_PH_TRIM: begin
				o_phase_a_phase_trim_q <= wdata[4:0];
			end
			`MCR_ADDR_B_PH_TRIM: begin
				o_phase_b_phase_trim_q <= wdata[4:0];
			end
			`MCR_ADDR_C_PH_TRIM: begin
				o_phase_c_phase_trim_q <= wdata[4:0];
			end
			`MCR_ADDR_A_PWR_OFS: begin
				o_phase_a_power_offset_q <= wdata[11:0];
			end
			`MCR_ADDR_B_PWR_OFS: begin
				o_phase_b_power_offset_q <= wdata[11:0];
			end
			`MCR_ADDR_C_PWR_OFS: begin
				o_phase_c_power_offset_q <= wdata[11:0];
			end
			`MCR_ADDR_PULSE_NUM: begin
				o_pulse_scale_numerator_q <= wdata[11:0];
			end
			`MCR_ADDR_PULSE_DEN: begin
				o_pulse_scale_denominator_q <= wdata[11:0];
			end
			`MCR_ADDR_ENERGY_DIV: begin
				o_active_energy_divider_q <= wdata[7:0];
			end
			default: begin
				// Addresses outside this bank belong to other blocks
			end
			endcase
		end
	end

	// ****************************************
	// Read-back
	// ****************************************
	// Narrow registers are zero-extended; foreign addresses read as zero
	always @* begin
		case (reg_addr)
		`MCR_ADDR_LINE_CYC: begin
			rdata = o_line_cycle_count_q;
		end
		`MCR_ADDR_SAG_CYC: begin
			rdata = {8'h00, o_sag_half_cycle_count_q};
		end
		`MCR_ADDR_SAG_LVL: begin
			rdata = {8'h00, o_sag_threshold_level_q};
		end
		`MCR_ADDR_V_PEAK: begin
			rdata = {8'h00, o_voltage_peak_threshold_q};
		end
		`MCR_ADDR_I_PEAK: begin
			rdata = {8'h00, o_current_peak_threshold_q};
		end
		`MCR_ADDR_GAIN_CFG: begin
			rdata = {8'h00, o_amplifier_gain_config_q};
		end
		`MCR_ADDR_A_WATT_GAIN: begin
			rdata = {4'h0, o_phase_a_watt_gain_q};
		end
		`MCR_ADDR_B_WATT_GAIN: begin
			rdata = {4'h0, o_phase_b_watt_gain_q};
		end
		`MCR_ADDR_C_WATT_GAIN: begin
			rdata = {4'h0, o_phase_c_watt_gain_q};
		end
		`MCR_ADDR_A_APP_GAIN: begin
			rdata = {4'h0, o_phase_a_apparent_gain_q};
		end
		`MCR_ADDR_B_APP_GAIN: begin
			rdata = {4'h0, o_phase_b_apparent_gain_q};
		end
		`MCR_ADDR_C_APP_GAIN: begin
			rdata = {4'h0, o_phase_c_apparent_gain_q};
		end
		`MCR_ADDR_A_PH_TRIM: begin
			rdata = {11'h000, o_phase_a_phase_trim_q};
		end
		`MCR_ADDR_B_PH_TRIM: begin
			rdata = {11'h000, o_phase_b_phase_trim_q};
		end
		`MCR_ADDR_C_PH_TRIM: begin
			rdata = {11'h000, o_phase_c_phase_trim_q};
		end
		`MCR_ADDR_A_PWR_OFS: begin
			rdata = {4'h0, o_phase_a_power_offset_q};
		end
		`MCR_ADDR_B_PWR_OFS: begin
			rdata = {4'h0, o_phase_b_power_offset_q};
		end
		`MCR_ADDR_C_PWR_OFS: begin
			rdata = {4'h0, o_phase_c_power_offset_q};
		end
		`MCR_ADDR_PULSE_NUM: begin
			rdata = {4'h0, o_pulse_scale_numerator_q};
		end
		`MCR_ADDR_PULSE_DEN: begin
			rdata = {4'h0, o_pulse_scale_denominator_q};
		end
		`MCR_ADDR_ENERGY_DIV: begin
			rdata = {8'h00, o_active_energy_divider_q};
		end
		default: begin
			rdata = 16'h0000;
		end
		endcase
	end

endmodule // mcr_regs
`default_nettype wire

// ### hw/mcr_serial_port.v
// Serial port engine: command byte, address decode and data shifting
`timescale 1ns/100ps
`default_nettype none
`include "mcr_defs.vh"

module mcr_serial_port (
	input  wire        i_clk,
	input  wire        i_reset,
	input  wire        i_sclk,
	input  wire        i_cs_n,
	input  wire        i_din,
	input  wire [15:0] i_rdata,
	output reg  [5:0]  o_addr_q,
	output reg         o_wr_pulse_q,
	output reg  [15:0] o_wdata_q,
	output reg         o_dout_q,
	output reg         o_dout_oe_q
);

	// Registers wider than one byte take two bytes on the wire
	function two_bytes;
		input [5:0] addr;
		begin
			two_bytes = (addr == `MCR_ADDR_LINE_CYC) ||
				(addr >= `MCR_ADDR_A_WATT_GAIN && addr <= `MCR_ADDR_C_APP_GAIN) ||
				(addr >= `MCR_ADDR_A_PWR_OFS && addr <= `MCR_ADDR_PULSE_DEN);
		end
	endfunction

	// ****************************************
	// Pin synchronisers
	// ****************************************
	reg        sclk_s1_q, sclk_s2_q, sclk_s3_q;
	reg        cs_n_s1_q, cs_n_s2_q;
	reg        din_s1_q,  din_s2_q;
	wire       sclk_rise = sclk_s2_q & ~sclk_s3_q;
	wire       sclk_fall = ~sclk_s2_q & sclk_s3_q;

	reg  [4:0]  bit_cnt_q;
	reg  [15:0] rx_q;
	reg  [15:0] tx_q;
	reg         is_wr_q;
	reg         wide_q;
	reg         load_q;
	reg         done_q;
	wire [15:0] rx_d    = {rx_q[14:0], din_s2_q};
	wire [5:0]  cmd_adr = rx_d[5:0];
	wire [4:0]  last_bit = wide_q ? 5'h18 : 5'h10;

	always @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			sclk_s1_q <= 1'b0;
			sclk_s2_q <= 1'b0;
			sclk_s3_q <= 1'b0;
			cs_n_s1_q <= 1'b1;
			cs_n_s2_q <= 1'b1;
			din_s1_q  <= 1'b0;
			din_s2_q  <= 1'b0;
		end else begin
			sclk_s1_q <= i_sclk;
			sclk_s2_q <= sclk_s1_q;
			sclk_s3_q <= sclk_s2_q;
			cs_n_s1_q <= i_cs_n;
			cs_n_s2_q <= cs_n_s1_q;
			din_s1_q  <= i_din;
			din_s2_q  <= din_s1_q;
		end
	end

	// ****************************************
	// Transfer sequencing
	// ****************************************
	always @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			bit_cnt_q    <= 5'h00;
			rx_q         <= 16'h0000;
			tx_q         <= 16'h0000;
			is_wr_q      <= 1'b0;
			wide_q       <= 1'b0;
			load_q       <= 1'b0;
			done_q       <= 1'b0;
			o_addr_q     <= 6'h00;
			o_wr_pulse_q <= 1'b0;
			o_wdata_q    <= 16'h0000;
			o_dout_q     <= 1'b0;
			o_dout_oe_q  <= 1'b0;
		end else begin
			o_wr_pulse_q <= 1'b0;
			load_q       <= 1'b0;
			if (cs_n_s2_q) begin
				// Deselect aborts a partial frame; a short write is dropped
				bit_cnt_q   <= 5'h00;
				done_q      <= 1'b0;
				o_dout_oe_q <= 1'b0;
			end else begin
				if (sclk_fall && !done_q) begin
					bit_cnt_q <= bit_cnt_q + 5'h01;
					rx_q      <= rx_d;
					if (bit_cnt_q == `MCR_CMD_BITS - 5'h01) begin
						o_addr_q <= cmd_adr;
						is_wr_q  <= rx_d[`MCR_CMD_WRITE_BIT];
						wide_q   <= two_bytes(cmd_adr);
						load_q   <= ~rx_d[`MCR_CMD_WRITE_BIT];
						rx_q     <= 16'h0000;
					end else if (bit_cnt_q == last_bit - 5'h01) begin
						done_q <= 1'b1;
						if (is_wr_q) begin
							o_wr_pulse_q <= 1'b1;
							o_wdata_q    <= wide_q ? rx_d : {8'h00, rx_d[7:0]};
						end
					end
				end
				// Read data is captured one cycle after the address settles
				if (load_q) begin
					tx_q        <= wide_q ? i_rdata : {i_rdata[7:0], 8'h00};
					o_dout_oe_q <= 1'b1;
				end else if (sclk_rise && bit_cnt_q >= `MCR_CMD_BITS && !is_wr_q) begin
					o_dout_q <= tx_q[15];
					tx_q     <= {tx_q[14:0], 1'b0};
				end
			end
		end
	end

endmodule // mcr_serial_port
`default_nettype wire
